// File: rtl/lps_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "lps_regs.svh"

module lps_core #(
  parameter logic [31:0] PMEAS_CYC   = `LPS_CYC_UP(`LPS_PMEAS_NS),
  parameter logic [31:0] LPERIOD_CYC = `LPS_CYC_UP(`LPS_LPERIOD_NS),
  parameter logic [31:0] SLPUNIT_CYC = `LPS_CYC_UP(`LPS_SLPUNIT_NS)
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic [7:0]  prox_adc_i,
  input  wire logic [11:0] light_adc_i,
  output logic             emitter_sink_pin_o,
  output logic             emitter_drive_sel_o,
  output logic [2:0]       light_range_sel_o,
  output logic [9:0]       light_full_scale_o,
  output logic             prox_out_of_range_o,
  output logic             light_out_of_range_o
);

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [6:0] sleep_units(input logic [2:0] c);
    unique case (c)
      3'h7: sleep_units = 7'h00;
      3'h6: sleep_units = 7'h01;
      3'h5: sleep_units = 7'h04;
      3'h4: sleep_units = 7'h06;
      3'h3: sleep_units = 7'h08;
      3'h2: sleep_units = 7'h10;
      3'h1: sleep_units = 7'h20;
      3'h0: sleep_units = 7'h40;
    endcase
  endfunction

  function automatic logic [9:0] full_scale(input logic [2:0] c);
    unique case (c)
      3'h0:    full_scale = 10'h320;
      3'h1:    full_scale = 10'h190;
      3'h2:    full_scale = 10'h0C8;
      3'h3:    full_scale = 10'h064;
      default: full_scale = 10'h032;
    endcase
  endfunction

  // ------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------
  logic [2:0] scl_s_reg;
  logic [2:0] sda_s_reg;
  logic       scl_f_reg;
  logic       sda_f_reg;
  logic       scl_p_reg;
  logic       sda_p_reg;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_s_reg <= {scl_s_reg[1:0], scl_i};
      sda_s_reg <= {sda_s_reg[1:0], sda_i};
      if (scl_s_reg[1] == scl_s_reg[2]) scl_f_reg <= scl_s_reg[2];
      if (sda_s_reg[1] == sda_s_reg[2]) sda_f_reg <= sda_s_reg[2];
      scl_p_reg <= scl_f_reg;
      sda_p_reg <= sda_f_reg;
    end
  end

  wire scl_rise  = scl_f_reg & ~scl_p_reg;
  wire scl_fall  = ~scl_f_reg & scl_p_reg;
  wire scl_hold  = scl_f_reg & scl_p_reg;
  wire start_det = scl_hold & sda_p_reg & ~sda_f_reg;
  wire stop_det  = scl_hold & ~sda_p_reg & sda_f_reg;

  // ------------------------------------------------
  // serial slave
  // ------------------------------------------------
  lps_pkg::lps_i2c_e st_reg;
  logic [3:0]        bit_reg;
  logic [7:0]        sh_reg;
  logic [7:0]        tx_reg;
  logic [7:0]        ptr_reg;
  logic              rw_reg;
  logic              nack_reg;
  logic              oe_reg;
  logic [7:0]        rd_byte;

  wire addr_hit = {sh_reg[7:1], 1'b0} == `LPS_ADDR_WR;
  wire byte_end = scl_fall & (bit_reg == 4'h8);
  wire wr_stb   = byte_end & ~start_det & ~stop_det
                & (st_reg == lps_pkg::I_WDAT);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_reg   <= lps_pkg::I_IDLE;
      bit_reg  <= 4'h0;
      sh_reg   <= 8'h00;
      tx_reg   <= 8'h00;
      ptr_reg  <= 8'h00;
      rw_reg   <= 1'b0;
      nack_reg <= 1'b0;
      oe_reg   <= 1'b0;
    end else if (stop_det) begin
      st_reg <= lps_pkg::I_IDLE;
      oe_reg <= 1'b0;
    end else if (start_det) begin
      st_reg  <= lps_pkg::I_ADDR;
      bit_reg <= 4'h0;
      oe_reg  <= 1'b0;
    end else if (scl_rise) begin
      sh_reg   <= {sh_reg[6:0], sda_f_reg};
      bit_reg  <= bit_reg + 4'h1;
      nack_reg <= sda_f_reg;
    end else if (scl_fall) begin
      unique case (st_reg)
        lps_pkg::I_IDLE: begin
        end
        lps_pkg::I_ADDR: if (byte_end) begin
          oe_reg <= addr_hit;
          rw_reg <= sh_reg[0];
          st_reg <= addr_hit ? lps_pkg::I_ACKA : lps_pkg::I_IDLE;
        end
        lps_pkg::I_ACKA: begin
          bit_reg <= 4'h0;
          tx_reg  <= rd_byte;
          oe_reg  <= rw_reg & ~rd_byte[7];
          st_reg  <= rw_reg ? lps_pkg::I_RDAT : lps_pkg::I_REG;
        end
        lps_pkg::I_REG: if (byte_end) begin
          ptr_reg <= sh_reg;
          oe_reg  <= 1'b1;
          st_reg  <= lps_pkg::I_ACKR;
        end
        lps_pkg::I_ACKR, lps_pkg::I_ACKW: begin
          bit_reg <= 4'h0;
          oe_reg  <= 1'b0;
          st_reg  <= lps_pkg::I_WDAT;
        end
        lps_pkg::I_WDAT: if (byte_end) begin
          ptr_reg <= ptr_reg + 8'h01;
          oe_reg  <= 1'b1;
          st_reg  <= lps_pkg::I_ACKW;
        end
        lps_pkg::I_RDAT: if (byte_end) begin
          ptr_reg <= ptr_reg + 8'h01;
          oe_reg  <= 1'b0;
          st_reg  <= lps_pkg::I_RACK;
        end else begin
          tx_reg <= {tx_reg[6:0], 1'b0};
          oe_reg <= ~tx_reg[6];
        end
        lps_pkg::I_RACK: begin
          // master nack ends the burst; wait for stop or restart
          bit_reg <= 4'h0;
          tx_reg  <= rd_byte;
          oe_reg  <= ~nack_reg & ~rd_byte[7];
          st_reg  <= nack_reg ? lps_pkg::I_IDLE : lps_pkg::I_RDAT;
        end
        default: st_reg <= lps_pkg::I_IDLE;
      endcase
    end
  end

  // ------------------------------------------------
  // register file
  // ------------------------------------------------
  logic [7:0]  cfg_reg;
  logic [7:0]  plo_reg;
  logic [7:0]  phi_reg;
  logic [7:0]  llo_reg;
  logic [7:0]  lmid_reg;
  logic [7:0]  lhi_reg;
  logic [2:0]  rng_reg;
  logic [7:0]  pres_reg;
  logic [11:0] lres_reg;

  wire [11:0] light_low_limit  = {lmid_reg[3:0], llo_reg};
  wire [11:0] light_high_limit = {lhi_reg, lmid_reg[7:4]};

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_reg  <= `LPS_RST_CFG;
      plo_reg  <= `LPS_RST_PLO;
      phi_reg  <= `LPS_RST_PHI;
      llo_reg  <= `LPS_RST_LLO;
      lmid_reg <= `LPS_RST_LMID;
      lhi_reg  <= `LPS_RST_LHI;
      rng_reg  <= `LPS_RST_RNG;
    end else if (wr_stb) begin
      unique case (ptr_reg)
        `LPS_ADDR_CFG:  cfg_reg  <= sh_reg & `LPS_CFG_MASK;
        `LPS_ADDR_PLO:  plo_reg  <= sh_reg;
        `LPS_ADDR_PHI:  phi_reg  <= sh_reg;
        `LPS_ADDR_LLO:  llo_reg  <= sh_reg;
        `LPS_ADDR_LMID: lmid_reg <= sh_reg;
        `LPS_ADDR_LHI:  lhi_reg  <= sh_reg;
        `LPS_ADDR_RNG:  rng_reg  <= sh_reg[2:0];
        default: begin
        end
      endcase
    end
  end

  // result registers and 0x02 are not writable from the bus
  always_comb begin
    unique case (ptr_reg)
      `LPS_ADDR_CFG:  rd_byte = cfg_reg;
      `LPS_ADDR_PLO:  rd_byte = plo_reg;
      `LPS_ADDR_PHI:  rd_byte = phi_reg;
      `LPS_ADDR_LLO:  rd_byte = llo_reg;
      `LPS_ADDR_LMID: rd_byte = lmid_reg;
      `LPS_ADDR_LHI:  rd_byte = lhi_reg;
      `LPS_ADDR_PRES: rd_byte = pres_reg;
      `LPS_ADDR_LRLO: rd_byte = lres_reg[7:0];
      `LPS_ADDR_LRHI: rd_byte = {4'h0, lres_reg[11:8]};
      `LPS_ADDR_RNG:  rd_byte = {5'h00, rng_reg};
      default:        rd_byte = 8'h00;
    endcase
  end

  wire       prox_en  = cfg_reg[`LPS_CFG_PEN];
  wire       light_en = cfg_reg[`LPS_CFG_LEN];
  wire [2:0] slp_sel  = cfg_reg[`LPS_CFG_SLP];

  // ------------------------------------------------
  // proximity sequencer
  // ------------------------------------------------
  lps_pkg::lps_prox_e pst_reg;
  lps_pkg::lps_prox_e pst_next;
  logic [31:0]        pcnt_reg;
  logic [31:0]        pcnt_next;

  wire [31:0] slp_cyc = {25'h0, sleep_units(slp_sel)} * SLPUNIT_CYC;
  wire prox_done = (pst_reg == lps_pkg::P_MEAS)
                 & (pcnt_reg == PMEAS_CYC - 32'h1);

  always_comb begin
    pst_next  = pst_reg;
    pcnt_next = pcnt_reg + 32'h1;
    if (!prox_en) begin
      pst_next  = lps_pkg::P_OFF;
      pcnt_next = 32'h0;
    end else begin
      unique case (pst_reg)
        lps_pkg::P_OFF: begin
          pst_next  = lps_pkg::P_MEAS;
          pcnt_next = 32'h0;
        end
        lps_pkg::P_MEAS: if (prox_done) begin
          pcnt_next = 32'h0;
          pst_next  = (slp_cyc == 32'h0) ? lps_pkg::P_MEAS
                                          : lps_pkg::P_SLEEP;
        end
        // compared from below: a switch to no sleep mid-sleep cannot stall
        lps_pkg::P_SLEEP: if (pcnt_reg + 32'h1 >= slp_cyc) begin
          pcnt_next = 32'h0;
          pst_next  = lps_pkg::P_MEAS;
        end
        default: begin
          pst_next  = lps_pkg::P_OFF;
          pcnt_next = 32'h0;
        end
      endcase
    end
  end

  // ------------------------------------------------
  // light timer
  // ------------------------------------------------
  logic [31:0] lcnt_reg;
  wire light_done = light_en & (lcnt_reg == LPERIOD_CYC - 32'h1);
  wire prox_oor   = (prox_adc_i < plo_reg)
                  | (prox_adc_i > phi_reg);
  wire light_oor  = (light_adc_i < light_low_limit)
                  | (light_adc_i > light_high_limit);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pst_reg  <= lps_pkg::P_OFF;
      pcnt_reg <= 32'h0;
      lcnt_reg <= 32'h0;
      pres_reg <= 8'h00;
      lres_reg <= 12'h000;
      prox_out_of_range_o  <= 1'b0;
      light_out_of_range_o <= 1'b0;
    end else begin
      pst_reg  <= pst_next;
      pcnt_reg <= pcnt_next;
      lcnt_reg <= (!light_en || light_done) ? 32'h0
                                            : lcnt_reg + 32'h1;
      if (prox_done) begin
        pres_reg            <= prox_adc_i;
        prox_out_of_range_o <= prox_oor;
      end
      if (light_done) begin
        lres_reg             <= light_adc_i;
        light_out_of_range_o <= light_oor;
      end
    end
  end

  // ------------------------------------------------
  // output flops
  // ------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sda_o               <= 1'b0;
      sda_oe_o            <= 1'b0;
      emitter_sink_pin_o  <= 1'b0;
      emitter_drive_sel_o <= 1'b0;
      light_range_sel_o   <= 3'h0;
      light_full_scale_o  <= 10'h320;
    end else begin
      sda_o               <= 1'b0;
      sda_oe_o            <= oe_reg;
      emitter_sink_pin_o  <= pst_next == lps_pkg::P_MEAS;
      emitter_drive_sel_o <= cfg_reg[`LPS_CFG_DRV];
      light_range_sel_o   <= rng_reg;
      light_full_scale_o  <= full_scale(rng_reg);
    end
  end

  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr(logic [7:0] a);
    wr_stb && ptr_reg == a;
  endsequence

  a_prox_low_wr: assert property (s_wr(`LPS_ADDR_PLO) |=>
    plo_reg == $past(sh_reg)) else $error("prox low limit not written");
  a_prox_high_wr: assert property (s_wr(`LPS_ADDR_PHI) |=>
    phi_reg == $past(sh_reg)) else $error("prox high limit not written");
  a_light_lim_pack: assert property (s_wr(`LPS_ADDR_LMID) |=>
    light_low_limit[11:8] == $past(sh_reg[3:0])
    && light_high_limit[3:0] == $past(sh_reg[7:4]))
    else $error("light limit packing wrong");
  a_prox_res_ro: assert property (s_wr(`LPS_ADDR_PRES) && !prox_done
    |=> $stable(pres_reg)) else $error("prox result written by bus");
  a_unused_zero: assert property ((ptr_reg == `LPS_ADDR_RNG
    || ptr_reg == `LPS_ADDR_LRHI) |-> rd_byte[7:4] == 4'h0)
    else $error("unused bits read nonzero");
  a_addr_match: assert property (st_reg == lps_pkg::I_ADDR
    && byte_end && !start_det && !stop_det |=> oe_reg == addr_hit)
    else $error("address ack wrong");
  a_light_gate: assert property (!light_en |-> !light_done)
    else $error("light result without enable");
  a_light_period: assert property (light_done |-> $past(light_en)
    && $past(lcnt_reg) == LPERIOD_CYC - 32'h2)
    else $error("light period wrong");
  a_prox_oor: assert property (prox_done |=> prox_out_of_range_o ==
    ($past(prox_adc_i) < $past(plo_reg)
    || $past(prox_adc_i) > $past(phi_reg)))
    else $error("prox window check wrong");
  a_light_oor: assert property (light_done |=> light_out_of_range_o ==
    ($past(light_adc_i) < $past(light_low_limit)
    || $past(light_adc_i) > $past(light_high_limit)))
    else $error("light window check wrong");
  a_meas_len: assert property (pst_reg == lps_pkg::P_SLEEP
    ##1 pst_reg == lps_pkg::P_MEAS |-> pcnt_reg == 32'h0)
    else $error("measurement start count wrong");
  a_sleep_skip: assert property (prox_done && prox_en
    && slp_sel == 3'h7 |=> pst_reg == lps_pkg::P_MEAS)
    else $error("no-sleep code inserted sleep");
  a_drive_sel: assert property (s_wr(`LPS_ADDR_CFG) ##1 1'b1
    |=> emitter_drive_sel_o == $past(sh_reg[3], 2))
    else $error("drive select not applied");
  a_scale_50: assert property (rng_reg[2] |=>
    light_full_scale_o == 10'h032) else $error("range scale wrong");

endmodule // lps_core

`default_nettype wire

// File: rtl/lps_regs.svh
`ifndef LPS_REGS_SVH
`define LPS_REGS_SVH

// --------------------------------------------------
// register offsets
// --------------------------------------------------
`define LPS_ADDR_CFG  8'h01
`define LPS_ADDR_PLO  8'h03
`define LPS_ADDR_PHI  8'h04
`define LPS_ADDR_LLO  8'h05
`define LPS_ADDR_LMID 8'h06
`define LPS_ADDR_LHI  8'h07
`define LPS_ADDR_PRES 8'h08
`define LPS_ADDR_LRLO 8'h09
`define LPS_ADDR_LRHI 8'h0A
`define LPS_ADDR_RNG  8'h0B

// bus address byte for writes; reads use it with bit 0 set
`define LPS_ADDR_WR   8'h88

// --------------------------------------------------
// reset values and fields
// --------------------------------------------------
`define LPS_RST_CFG   8'h00
`define LPS_RST_PLO   8'h00
`define LPS_RST_PHI   8'hFF
`define LPS_RST_LLO   8'h00
`define LPS_RST_LMID  8'hF0
`define LPS_RST_LHI   8'hFF
`define LPS_RST_RNG   3'h0
`define LPS_CFG_MASK  8'hFC
`define LPS_CFG_PEN   7
`define LPS_CFG_SLP   6:4
`define LPS_CFG_DRV   3
`define LPS_CFG_LEN   2

// --------------------------------------------------
// timing
// --------------------------------------------------
`define LPS_CLK_NS      25
`define LPS_PMEAS_NS    540000
`define LPS_LPERIOD_NS  100000000
`define LPS_SLPUNIT_NS  12500000
`define LPS_CYC_UP(ns) (((ns) + `LPS_CLK_NS - 1) / `LPS_CLK_NS)

`endif

// File: rtl/lps_pkg.sv
`default_nettype none

package lps_pkg;

  typedef enum logic [3:0] {
    I_IDLE = 4'b0000,
    I_ADDR = 4'b0001,
    I_ACKA = 4'b0010,
    I_REG  = 4'b0011,
    I_ACKR = 4'b0100,
    I_WDAT = 4'b0101,
    I_ACKW = 4'b0110,
    I_RDAT = 4'b0111,
    I_RACK = 4'b1000
  } lps_i2c_e;

  typedef enum logic [1:0] {
    P_OFF   = 2'b00,
    P_MEAS  = 2'b01,
    P_SLEEP = 2'b10
  } lps_prox_e;

endpackage

`default_nettype wire

// File: tb/lps_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "lps_regs.svh"

// --------------------------------------------------
// bus master on the far side of the register port
// --------------------------------------------------
module lps_host_model #(
  parameter int HALF = 10
) (
  input  wire logic sys_clk_i,
  input  wire logic sda_i,
  output var logic  scl_oe_o,
  output var logic  sda_oe_o
);
  // both lines released: the bus clock stands still between frames
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // data moves well after scl falls, past the slave's filter lag
  task automatic put_bit(input logic b, output logic s);
    sda_oe_o <= ~b;
    hold(HALF);
    scl_oe_o <= 1'b0;
    hold(HALF);
    s = sda_i;
    scl_oe_o <= 1'b1;
    hold(6);
  endtask

  // serves as first start from idle and as repeated start
  task automatic start_cond;
    sda_oe_o <= 1'b0;
    hold(HALF);
    scl_oe_o <= 1'b0;
    hold(HALF);
    sda_oe_o <= 1'b1;
    hold(HALF);
    scl_oe_o <= 1'b1;
    hold(6);
  endtask

  task automatic stop_cond;
    sda_oe_o <= 1'b1;
    hold(HALF);
    scl_oe_o <= 1'b0;
    hold(HALF);
    sda_oe_o <= 1'b0;
    hold(HALF);
  endtask

  task automatic xfer(input logic [7:0] v, input logic ninth,
                      output logic [7:0] r, output logic s9);
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], r[i]);
    end
    put_bit(ninth, s9);
  endtask

  task automatic send(input logic [7:0] v, inout logic ok);
    logic [7:0] r;
    logic       s;
    xfer(v, 1'b1, r, s);
    ok = ok & ~s;
  endtask

  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d,
                        output logic ok);
    ok = 1'b1;
    start_cond();
    send(`LPS_ADDR_WR, ok);
    send(ptr, ok);
    send(d, ok);
    stop_cond();
  endtask

  // five threshold bytes from the proximity low limit upward
  task automatic thr_wr(input logic [39:0] d, output logic ok);
    ok = 1'b1;
    start_cond();
    send(`LPS_ADDR_WR, ok);
    send(`LPS_ADDR_PLO, ok);
    for (int i = 4; i >= 0; i--) begin
      send(d[i*8 +: 8], ok);
    end
    stop_cond();
  endtask

  task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] d,
                        output logic ok);
    logic s;
    ok = 1'b1;
    start_cond();
    send(`LPS_ADDR_WR, ok);
    send(ptr, ok);
    start_cond();
    send(`LPS_ADDR_WR | 8'h01, ok);
    xfer(8'hFF, 1'b1, d, s);
    stop_cond();
  endtask

  task automatic probe(input logic [7:0] a, output logic ok);
    ok = 1'b1;
    start_cond();
    send(a, ok);
    stop_cond();
  endtask
endmodule // lps_host_model
`default_nettype wire

// File: tb/test_light_proximity_sensor_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "lps_regs.svh"

module test_light_proximity_sensor_regs;
  localparam logic [31:0] PMEAS   = 32'h8;
  localparam logic [31:0] SLPUNIT = 32'h4;
  localparam logic [7:0]  RSTV [9] = '{8'h00, 8'hFF, 8'h00, 8'hF0, 8'hFF,
                                       8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0]  P_IN [3] = '{8'h10, 8'hD0, 8'h80};
  localparam logic [11:0] L_IN [3] = '{12'h0FF, 12'h900, 12'h4A5};
  localparam logic [9:0]  FS [8]   = '{10'h320, 10'h190, 10'h0C8, 10'h064,
                                       10'h032, 10'h032, 10'h032, 10'h032};
  localparam logic [7:0]  SLP_U [8] = '{8'h40, 8'h20, 8'h10, 8'h08,
                                        8'h06, 8'h04, 8'h01, 8'h00};

  logic        sys_clk;
  logic        rst;
  logic [7:0]  prox_adc;
  logic [11:0] light_adc;
  logic        dut_sda;
  logic        dut_sda_oe;
  logic        host_scl_oe;
  logic        host_sda_oe;
  logic        emitter;
  logic        drive_sel;
  logic        prox_oor;
  logic        light_oor;
  logic [2:0]  range_sel;
  logic [9:0]  full_scale;
  wire logic   scl_line;
  wire logic   sda_line;
  int          err_count;
  int          checks_done;

  // --------------------------------------------------
  // open-drain lines with pull-ups
  // --------------------------------------------------
  assign scl_line = ~host_scl_oe;
  assign sda_line = dut_sda_oe ? dut_sda : ~host_sda_oe;

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  lps_core #(
    .PMEAS_CYC   (PMEAS),
    .LPERIOD_CYC (32'h14),
    .SLPUNIT_CYC (SLPUNIT)
  ) i_dut (
    .sys_clk_i            (sys_clk),
    .rst_i                (rst),
    .scl_i                (scl_line),
    .sda_i                (sda_line),
    .sda_o                (dut_sda),
    .sda_oe_o             (dut_sda_oe),
    .prox_adc_i           (prox_adc),
    .light_adc_i          (light_adc),
    .emitter_sink_pin_o   (emitter),
    .emitter_drive_sel_o  (drive_sel),
    .light_range_sel_o    (range_sel),
    .light_full_scale_o   (full_scale),
    .prox_out_of_range_o  (prox_oor),
    .light_out_of_range_o (light_oor)
  );

  lps_host_model i_host (
    .sys_clk_i (sys_clk),
    .sda_i     (sda_line),
    .scl_oe_o  (host_scl_oe),
    .sda_oe_o  (host_sda_oe)
  );

  // --------------------------------------------------
  // checking and access helpers
  // --------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    i_host.reg_wr(p, d, ok);
    check("write_ack", 16'(ok), 16'h1);
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [7:0] e,
                        input string name);
    logic [7:0] d;
    logic       ok;
    i_host.reg_rd(p, d, ok);
    check("read_ack", 16'(ok), 16'h1);
    check(name, 16'(d), 16'(e));
  endtask

  // bounded wait for a level on the emitter; n counts the cycles spent
  task automatic wait_emit(input logic v, output int n);
    n = 0;
    while (emitter !== v && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    check("emitter_wait", 16'(n < 4000), 16'h1);
  endtask

  initial begin
    repeat (80000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end

  // --------------------------------------------------
  // test sequence
  // --------------------------------------------------
  initial begin
    int   n;
    int   gap;
    logic ok;
    rst = 1'b1;
    prox_adc = 8'h00;
    light_adc = 12'h000;
    err_count = 0;
    checks_done = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      rd_chk(8'h03 + i[7:0], RSTV[i], "reset_value");
    end
    i_host.probe(8'hA0, ok);
    check("foreign_addr_ack", 16'(ok), 16'h0);
    i_host.thr_wr(40'h20_C0_00_01_80, ok);
    check("burst_ack", 16'(ok), 16'h1);
    rd_chk(`LPS_ADDR_PLO, 8'h20, "prox_low");
    rd_chk(`LPS_ADDR_PHI, 8'hC0, "prox_high");
    rd_chk(`LPS_ADDR_LLO, 8'h00, "light_low_lo");
    rd_chk(`LPS_ADDR_LMID, 8'h01, "light_mid");
    rd_chk(`LPS_ADDR_LHI, 8'h80, "light_high_hi");
    // no sleep, 200 mA, both sensors on
    wr(`LPS_ADDR_CFG, 8'hFC);
    check("drive_sel", 16'(drive_sel), 16'h1);
    for (int i = 0; i < 3; i++) begin
      prox_adc <= P_IN[i];
      light_adc <= L_IN[i];
      repeat (100) @(posedge sys_clk);
      rd_chk(`LPS_ADDR_PRES, P_IN[i], "prox_result");
      rd_chk(`LPS_ADDR_LRLO, L_IN[i][7:0], "light_lo");
      rd_chk(`LPS_ADDR_LRHI, {4'h0, L_IN[i][11:8]}, "light_hi");
      check("prox_flag", 16'(prox_oor), 16'(i < 2));
      check("light_flag", 16'(light_oor), 16'(i < 2));
    end
    wr(`LPS_ADDR_CFG, 8'h00);
    prox_adc <= 8'h33;
    light_adc <= 12'h555;
    repeat (200) @(posedge sys_clk);
    check("emitter_off", 16'(emitter), 16'h0);
    rd_chk(`LPS_ADDR_LRLO, 8'hA5, "light_held");
    wr(`LPS_ADDR_PRES, 8'h5A);
    rd_chk(`LPS_ADDR_PRES, 8'h80, "prox_read_only");
    for (int i = 0; i < 8; i++) begin
      wr(`LPS_ADDR_RNG, {5'h00, i[2:0]});
      check("range_sel", 16'(range_sel), 16'(i[2:0]));
      check("full_scale", 16'(full_scale), 16'(FS[i]));
      rd_chk(`LPS_ADDR_RNG, {5'h00, i[2:0]}, "range_read");
    end
    for (int i = 0; i < 8; i++) begin
      wr(`LPS_ADDR_CFG, {1'b1, i[2:0], 4'h0});
      check("drive_sel", 16'(drive_sel), 16'h0);
      wait_emit(1'b1, n);
      if (i == 7) begin
        // no sleep: measurements run back to back, emitter never drops
        n = 0;
        repeat (40) begin
          @(posedge sys_clk);
          if (emitter !== 1'b1) n++;
        end
        check("emitter_run", 16'(n), 16'h0);
      end else begin
        wait_emit(1'b0, n);
        wait_emit(1'b1, gap);
        wait_emit(1'b0, n);
        check("meas_len", 16'(n), 16'(PMEAS));
        n = int'(SLP_U[i]) * int'(SLPUNIT);
        check("sleep_gap", 16'(gap >= n && gap <= n + 2), 16'h1);
      end
    end
    give_verdict();
  end
endmodule // test_light_proximity_sensor_regs
`default_nettype wire
